/* File: hw/stwd_pkg.sv */
// ************************************************************
// Package of the slow tick timer and watchdog.
// ************************************************************
package stwd_pkg;

    // ************************************************************
    // Register byte addresses on the peripheral bus.
    // ************************************************************
    localparam logic [7:0] OFS_CONFIG     = 8'h00;
    localparam logic [7:0] OFS_PRESCALE   = 8'h04;
    localparam logic [7:0] OFS_PRESET     = 8'h08;
    localparam logic [7:0] OFS_CTRL       = 8'h0C;
    localparam logic [7:0] OFS_RELOAD     = 8'h10;
    localparam logic [7:0] OFS_KEY        = 8'h14;
    localparam logic [7:0] OFS_IRQ_STATUS = 8'h18;
    localparam logic [7:0] OFS_IRQ_MASK   = 8'h1C;

    // ************************************************************
    // Field positions.
    // ************************************************************
    localparam int CFG_CLK_SEL_BIT = 4;
    localparam int CFG_KEY_EN_BIT  = 5;
    localparam int CTRL_RESTART    = 0;
    localparam int CTRL_TC         = 1;
    localparam int CTRL_INT_EN     = 2;
    localparam int CTRL_PENDING    = 3;
    localparam int CTRL_FREEZE_EN  = 4;
    localparam int DIV_W           = 3;
    localparam int IRQ_W           = 2;
    localparam int IRQ_TICK        = 0;
    localparam int IRQ_SERVICE     = 1;

    // ************************************************************
    // Reset values and codes.
    // ************************************************************
    localparam logic [15:0]      PRESET_RESET = 16'hFFFF;
    localparam logic [7:0]       RELOAD_RESET = 8'h0F;
    localparam logic [7:0]       KEY_MATCH    = 8'h5C;
    localparam logic [DIV_W-1:0] DIV_RESET    = 3'h0;
    localparam logic [DIV_W-1:0] DIV_MAX_CODE = 3'h5;
    localparam int               PRE_CNT_W    = 5;

    typedef struct packed {
        logic                 key_en;
        logic                 clk_sel;
        logic [DIV_W-1:0]     div;
        logic [PRE_CNT_W-1:0] pre_cnt;
        logic [15:0]          preset;
        logic [15:0]          tmr;
        logic                 rst_req;
        logic                 tc;
        logic                 int_en;
        logic                 freeze_en;
        logic                 tick_out;
        logic [7:0]           reload;
        logic [7:0]           wd_cnt;
        logic                 wd_started;
        logic                 serviced;
        logic                 wd_error;
        logic [IRQ_W-1:0]     irq_status;
        logic [IRQ_W-1:0]     irq_mask;
        logic                 irq;
        logic [31:0]          prdata;
        logic                 pready;
        logic                 pslverr;
    } stwd_state_s;

endpackage

/* File: hw/stwd_top.sv */
// Overview of operation
// - Tick input clock is slow clock divided by 1..32 for divider codes 0..5.
// - Prescale byte is read/write, divider in bits 2..0, reset gives divide-by-one.
// - Sixteen-bit preset register is read/write and resets to FFFFh.
// - Timer reloads preset on each underflow; software keeps preset nonzero.
// - Control byte: restart, terminal count, interrupt enable, pending, freeze enable.
// - Debug freeze stops the timer only while freeze enable is set.
// - Reload byte is write-only, resets to 0Fh, first write starts watchdog.
// - Each later reload write reloads the watchdog counter with written value.
// - With key servicing on, writing 5Ch reloads counter from reload register.
// - With key servicing on, any other key byte raises a watchdog error.
// - Two key writes within one watchdog clock cycle raise a watchdog error.
// - With key servicing off, key writes are ignored entirely.
// - Clock select clear uses tick output pulse, set uses tick input clock.
// - At zero, pulse output one tick cycle, set flag, interrupt only if enabled.
// - Restart request reloads timer at next tick input edge, then clears itself.
// - Any watchdog error raises wd_reset_req, which stays high until presetn.
//
// Register access over APB and the register addresses were decided locally.
`timescale 1ns/1ps
`default_nettype none
module stwd_top #(
    parameter int PRE_CNT_W = stwd_pkg::PRE_CNT_W
) (
    // Clock and reset.
    input  wire logic        pclk,
    input  wire logic        presetn,
    // Peripheral bus.
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output var  logic [31:0] prdata,
    output var  logic        pready,
    output var  logic        pslverr,
    // Slow clock and debug.
    input  wire logic        slow_tick,
    input  wire logic        debug_freeze,
    // Results.
    output var  logic        tick_output_pulse,
    output var  logic        irq,
    output var  logic        wd_reset_req
);

    // ************************************************************
    // Elaboration check.
    // ************************************************************
    if (PRE_CNT_W != stwd_pkg::PRE_CNT_W) begin : g_bad_width
        $error("Prescale counter must be exactly five bits for divide-by-32.");
    end

    stwd_pkg::stwd_state_s s_r;
    stwd_pkg::stwd_state_s s_nxt;

    logic                             acc;
    logic                             wr_done;
    logic                             rd_done;
    logic                             hit;
    logic [31:0]                      rdata;
    logic [stwd_pkg::DIV_W-1:0]       eff_div;
    logic [stwd_pkg::PRE_CNT_W-1:0]   pre_mask;
    logic                             tick_in;
    logic                             run;
    logic                             tick_evt;
    logic                             wd_clk;
    logic                             key_wr;
    logic                             reload_wr;
    logic                             ctrl_wr;
    logic                             key_ok;

    // ************************************************************
    // Tick input and watchdog clock events.
    // ************************************************************
    always_comb begin
        // Reserved divider codes fall back to the slowest rate rather than stalling the timer.
        eff_div  = (s_r.div > stwd_pkg::DIV_MAX_CODE) ? stwd_pkg::DIV_MAX_CODE : s_r.div;
        pre_mask = PRE_CNT_W'((6'h01 << eff_div) - 6'h01);
        tick_in  = slow_tick & ((s_r.pre_cnt & pre_mask) == pre_mask);
        run      = ~(s_r.freeze_en & debug_freeze);
        tick_evt = tick_in & run & ~s_r.rst_req & (s_r.tmr == 16'h0000);
        wd_clk   = s_r.clk_sel ? tick_in : tick_evt;
    end

    // ************************************************************
    // Bus decode.
    // ************************************************************
    always_comb begin
        acc       = psel & penable;
        wr_done   = acc & s_r.pready & pwrite;
        rd_done   = acc & s_r.pready & ~pwrite;
        reload_wr = wr_done & (paddr == stwd_pkg::OFS_RELOAD);
        key_wr    = wr_done & (paddr == stwd_pkg::OFS_KEY);
        ctrl_wr   = wr_done & (paddr == stwd_pkg::OFS_CTRL);
        key_ok    = (pwdata[7:0] == stwd_pkg::KEY_MATCH) & ~s_r.serviced;
        hit       = 1'b1;
        rdata     = 32'h0000_0000;
        unique case (paddr)
            stwd_pkg::OFS_CONFIG: begin
                rdata[stwd_pkg::CFG_CLK_SEL_BIT] = s_r.clk_sel;
                rdata[stwd_pkg::CFG_KEY_EN_BIT]  = s_r.key_en;
            end
            stwd_pkg::OFS_PRESCALE: begin
                rdata[stwd_pkg::DIV_W-1:0] = s_r.div;
            end
            stwd_pkg::OFS_PRESET: begin
                rdata[15:0] = s_r.preset;
            end
            stwd_pkg::OFS_CTRL: begin
                rdata[stwd_pkg::CTRL_RESTART]   = s_r.rst_req;
                rdata[stwd_pkg::CTRL_TC]        = s_r.tc;
                rdata[stwd_pkg::CTRL_INT_EN]    = s_r.int_en;
                rdata[stwd_pkg::CTRL_PENDING]   = s_r.serviced;
                rdata[stwd_pkg::CTRL_FREEZE_EN] = s_r.freeze_en;
            end
            stwd_pkg::OFS_RELOAD: begin
                rdata = 32'h0000_0000;
            end
            stwd_pkg::OFS_KEY: begin
                rdata = 32'h0000_0000;
            end
            stwd_pkg::OFS_IRQ_STATUS: begin
                rdata[stwd_pkg::IRQ_W-1:0] = s_r.irq_status;
            end
            stwd_pkg::OFS_IRQ_MASK: begin
                rdata[stwd_pkg::IRQ_W-1:0] = s_r.irq_mask;
            end
            default: begin
                hit = 1'b0;
            end
        endcase
    end

    // ************************************************************
    // Next state.
    // ************************************************************
    always_comb begin
        s_nxt = s_r;

        // One wait state: data is prepared in the first access cycle and shown with pready.
        s_nxt.pready  = acc & ~s_r.pready;
        s_nxt.pslverr = acc & ~s_r.pready & ~hit;
        s_nxt.prdata  = (acc & ~s_r.pready & ~pwrite & hit) ? rdata : 32'h0000_0000;

        // Prescaler and tick timer.
        if (slow_tick) begin
            s_nxt.pre_cnt = s_r.pre_cnt + PRE_CNT_W'(1);
        end
        if (tick_in & run) begin
            s_nxt.tick_out = tick_evt;
            if (s_r.rst_req) begin
                s_nxt.tmr     = s_r.preset;
                s_nxt.rst_req = 1'b0;
            end else if (s_r.tmr == 16'h0000) begin
                s_nxt.tmr = s_r.preset;
            end else begin
                s_nxt.tmr = s_r.tmr - 16'h0001;
            end
        end

        // Read-to-clear drops only the bits that the completed read actually returned,
        // so an event landing between sampling and completion is kept.
        if (rd_done & (paddr == stwd_pkg::OFS_CTRL) & s_r.prdata[stwd_pkg::CTRL_TC]) begin
            s_nxt.tc = 1'b0;
        end
        if (rd_done & (paddr == stwd_pkg::OFS_IRQ_STATUS)) begin
            s_nxt.irq_status = s_r.irq_status & ~s_r.prdata[stwd_pkg::IRQ_W-1:0];
        end
        if (tick_evt) begin
            s_nxt.tc = 1'b1;
        end
        if (tick_evt & s_r.int_en) begin
            s_nxt.irq_status[stwd_pkg::IRQ_TICK] = 1'b1;
        end

        // Watchdog counting.
        if (s_r.wd_started & wd_clk) begin
            s_nxt.serviced = 1'b0;
            if (s_r.wd_cnt == 8'h00) begin
                s_nxt.wd_error = 1'b1;
            end else begin
                s_nxt.wd_cnt = s_r.wd_cnt - 8'h01;
            end
        end

        // Register writes.
        if (wr_done) begin
            unique case (paddr)
                stwd_pkg::OFS_CONFIG: begin
                    s_nxt.clk_sel = pwdata[stwd_pkg::CFG_CLK_SEL_BIT];
                    s_nxt.key_en  = pwdata[stwd_pkg::CFG_KEY_EN_BIT];
                end
                stwd_pkg::OFS_PRESCALE: begin
                    s_nxt.div = pwdata[stwd_pkg::DIV_W-1:0];
                end
                stwd_pkg::OFS_PRESET: begin
                    s_nxt.preset = pwdata[15:0];
                end
                stwd_pkg::OFS_CTRL: begin
                    // Writing zero to the restart bit has no effect.
                    s_nxt.rst_req   = s_nxt.rst_req | pwdata[stwd_pkg::CTRL_RESTART];
                    s_nxt.int_en    = pwdata[stwd_pkg::CTRL_INT_EN];
                    s_nxt.freeze_en = pwdata[stwd_pkg::CTRL_FREEZE_EN];
                end
                stwd_pkg::OFS_RELOAD: begin
                    s_nxt.reload     = pwdata[7:0];
                    s_nxt.wd_cnt     = pwdata[7:0];
                    s_nxt.wd_started = 1'b1;
                    s_nxt.serviced   = 1'b1;
                    s_nxt.irq_status[stwd_pkg::IRQ_SERVICE] = 1'b1;
                end
                stwd_pkg::OFS_KEY: begin
                    if (s_r.key_en) begin
                        if (key_ok) begin
                            s_nxt.wd_cnt     = s_r.reload;
                            s_nxt.wd_started = 1'b1;
                            s_nxt.serviced   = 1'b1;
                            s_nxt.irq_status[stwd_pkg::IRQ_SERVICE] = 1'b1;
                        end else begin
                            s_nxt.wd_error = 1'b1;
                        end
                    end
                end
                stwd_pkg::OFS_IRQ_MASK: begin
                    s_nxt.irq_mask = pwdata[stwd_pkg::IRQ_W-1:0];
                end
                default: begin
                end
            endcase
        end

        s_nxt.irq = |(s_nxt.irq_status & s_nxt.irq_mask);
    end

    // ************************************************************
    // State register.
    // ************************************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_r            <= '0;
            s_r.div        <= stwd_pkg::DIV_RESET;
            s_r.preset     <= stwd_pkg::PRESET_RESET;
            s_r.tmr        <= stwd_pkg::PRESET_RESET;
            s_r.reload     <= stwd_pkg::RELOAD_RESET;
            s_r.wd_cnt     <= stwd_pkg::RELOAD_RESET;
        end else begin
            s_r <= s_nxt;
        end
    end

    always_comb begin
        prdata            = s_r.prdata;
        pready            = s_r.pready;
        pslverr           = s_r.pslverr;
        tick_output_pulse = s_r.tick_out;
        irq               = s_r.irq;
        wd_reset_req      = s_r.wd_error;
    end

    // ************************************************************
    // Assertions.
    // ************************************************************
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    property p_div_one;
        slow_tick && s_r.div == 3'h0 |-> tick_in;
    endproperty
    a_div_one: assert property (p_div_one) else $error("Divide-by-one missed a tick.");

    property p_underflow_reload;
        tick_in && run && !s_r.rst_req && s_r.tmr == 16'h0000 |=> s_r.tmr == $past(s_r.preset);
    endproperty
    a_underflow_reload: assert property (p_underflow_reload) else $error("No reload on underflow.");

    property p_freeze_hold;
        s_r.freeze_en && debug_freeze |=> $stable(s_r.tmr);
    endproperty
    a_freeze_hold: assert property (p_freeze_hold) else $error("Timer moved while frozen.");

    property p_tc_and_pulse;
        tick_evt |=> s_r.tc && s_r.tick_out;
    endproperty
    a_tc_and_pulse: assert property (p_tc_and_pulse) else $error("Zero reach lost flag or pulse.");

    property p_irq_gated;
        $rose(s_r.irq_status[stwd_pkg::IRQ_TICK]) |-> $past(s_r.int_en);
    endproperty
    a_irq_gated: assert property (p_irq_gated) else $error("Tick event without enable.");

    property p_restart;
        tick_in && run && s_r.rst_req && !ctrl_wr |=> !s_r.rst_req && s_r.tmr == $past(s_r.preset);
    endproperty
    a_restart: assert property (p_restart) else $error("Restart not taken or not cleared.");

    property p_reload_write;
        reload_wr |=> s_r.wd_started && s_r.wd_cnt == $past(pwdata[7:0]);
    endproperty
    a_reload_write: assert property (p_reload_write) else $error("Reload write not applied.");

    property p_key_good;
        key_wr && s_r.key_en && key_ok |=> s_r.wd_cnt == $past(s_r.reload);
    endproperty
    a_key_good: assert property (p_key_good) else $error("Key did not reload counter.");

    property p_key_bad;
        key_wr && s_r.key_en && pwdata[7:0] != stwd_pkg::KEY_MATCH |=> s_r.wd_error;
    endproperty
    a_key_bad: assert property (p_key_bad) else $error("Wrong key without error.");

    property p_key_twice;
        key_wr && s_r.key_en && s_r.serviced && !wd_clk |=> s_r.wd_error;
    endproperty
    a_key_twice: assert property (p_key_twice) else $error("Double key without error.");

    property p_key_off;
        key_wr && !s_r.key_en && !s_r.wd_error && !(s_r.wd_started && wd_clk) |=> $stable(s_r.wd_cnt) && !s_r.wd_error;
    endproperty
    a_key_off: assert property (p_key_off) else $error("Disabled key write had effect.");

    property p_late;
        s_r.wd_started && wd_clk && s_r.wd_cnt == 8'h00 |=> wd_reset_req;
    endproperty
    a_late: assert property (p_late) else $error("Late service not reported.");

    property p_error_sticky;
        wd_reset_req |=> wd_reset_req;
    endproperty
    a_error_sticky: assert property (p_error_sticky) else $error("Watchdog reset request dropped.");

    property p_idle_until_start;
        !s_r.wd_started && !reload_wr && !key_wr |=> $stable(s_r.wd_cnt) && !s_r.wd_started;
    endproperty
    a_idle_until_start: assert property (p_idle_until_start) else $error("Watchdog moved before start.");

    property p_pending_clear;
        s_r.wd_started && wd_clk && !reload_wr && !key_wr |=> !s_r.serviced;
    endproperty
    a_pending_clear: assert property (p_pending_clear) else $error("Service flag not cleared.");

    property p_pulse_hold;
        !(tick_in && run) |=> $stable(s_r.tick_out);
    endproperty
    a_pulse_hold: assert property (p_pulse_hold) else $error("Tick pulse moved off a tick input.");

endmodule
`default_nettype wire

/* File: tb/slow_tick_timer_and_watchdog_test.sv */
`timescale 1ns/1ps
`default_nettype none
module slow_tick_timer_and_watchdog_test;
    // ************************************************************
    // Signals and design.
    // ************************************************************
    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        slow_tick = 1'b0;
    logic        debug_freeze = 1'b0;
    logic        tick_output_pulse;
    logic        irq;
    logic        wd_reset_req;
    logic [1:0]  sdiv = 2'h0;
    logic [31:0] rdat;
    logic        rerr;
    int          n_mismatch = 0;
    int          n_checks = 0;
    int          per;

    stwd_top DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .slow_tick(slow_tick), .debug_freeze(debug_freeze), .tick_output_pulse(tick_output_pulse),
        .irq(irq), .wd_reset_req(wd_reset_req));

    always #5 pclk = ~pclk;

    // The slow clock is an enable on every fourth bus clock, so one tick input is 4 << div cycles.
    always @(posedge pclk) begin
        sdiv <= sdiv + 2'h1;
        slow_tick <= (sdiv == 2'h3);
    end

    // ************************************************************
    // Shared tasks.
    // ************************************************************
    task automatic print_verdict();
        $display("mismatches %0d checks %0d", n_mismatch, n_checks);
        if (n_mismatch == 0 && n_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    task automatic fail(input string msg);
        n_mismatch++;
        $display("CHECK FAILED at %0t: %s", $time, msg);
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
        n_checks++;
        if (got !== exp) begin
            fail($sformatf("%s got %h expected %h", msg, got, exp));
        end
    endtask

    // One transfer; an idle cycle follows so that the next setup never lands in the same time step.
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int k;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge pclk);
            k++;
        end while (pready !== 1'b1 && k < 50);
        rdat = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
        if (k >= 50) begin
            fail("bus answer timeout");
            print_verdict();
        end
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic [31:0] msk);
        apb(1'b0, a, 32'h0);
        chk(rdat & msk, exp, "read data");
    endtask

    // Cycles until the next rising edge of the tick pulse; a missing edge ends the run when expected.
    task automatic rise(input int bound, input logic expect_it, output int n);
        logic p;
        for (n = 1; n <= bound; n++) begin
            p = tick_output_pulse;
            @(posedge pclk);
            if (p === 1'b0 && tick_output_pulse === 1'b1) begin
                break;
            end
        end
        if (n > bound && expect_it) begin
            fail("tick pulse never rose");
            print_verdict();
        end
    endtask

    // Level watch of irq (sel 1) or watchdog reset request (sel 2).
    task automatic watch(input int sel, input int cyc, input logic exp_high);
        int  k;
        logic seen;
        seen = 1'b0;
        for (k = 0; k < cyc && !seen; k++) begin
            @(posedge pclk);
            seen = ((sel == 1) ? irq : wd_reset_req) === 1'b1;
        end
        chk({31'h0, seen}, {31'h0, exp_high}, "output level");
        if (exp_high && !seen) begin
            print_verdict();
        end
    endtask

    task automatic do_reset();
        presetn <= 1'b0;
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
    endtask

    // ************************************************************
    // Main sequence.
    // ************************************************************
    initial begin
        do_reset();
        rd(stwd_pkg::OFS_PRESCALE, 32'h0, 32'hFF);
        rd(stwd_pkg::OFS_PRESET, 32'hFFFF, 32'hFFFF);
        rd(stwd_pkg::OFS_CTRL, 32'h0, 32'hFF);
        rd(stwd_pkg::OFS_RELOAD, 32'h0, 32'hFFFFFFFF);
        apb(1'b0, 8'h40, 32'h0);
        chk({31'h0, rerr}, 32'h1, "unmapped error");
        watch(2, 300, 1'b0);
        apb(1'b1, stwd_pkg::OFS_PRESET, 32'h1234);
        rd(stwd_pkg::OFS_PRESET, 32'h1234, 32'hFFFF);
        // Every divider code 0..5 with the smallest legal preset.
        for (int d = 0; d < 6; d++) begin
            apb(1'b1, stwd_pkg::OFS_PRESET, 32'h1);
            apb(1'b1, stwd_pkg::OFS_PRESCALE, 32'(d));
            rd(stwd_pkg::OFS_PRESCALE, 32'(d), 32'hFF);
            apb(1'b1, stwd_pkg::OFS_CTRL, 32'h1);
            rise(3000, 1'b1, per);
            rise(3000, 1'b1, per);
            chk(32'(per), 32'(8 << d), "tick period");
        end
        rd(stwd_pkg::OFS_CTRL, 32'h2, 32'h3);
        // Interrupt: masked, unmasked, then disabled at the source.
        apb(1'b1, stwd_pkg::OFS_PRESCALE, 32'h0);
        apb(1'b1, stwd_pkg::OFS_PRESET, 32'h2);
        apb(1'b1, stwd_pkg::OFS_CTRL, 32'h5);
        watch(1, 100, 1'b0);
        apb(1'b1, stwd_pkg::OFS_IRQ_MASK, 32'h1);
        watch(1, 100, 1'b1);
        rd(stwd_pkg::OFS_IRQ_STATUS, 32'h1, 32'h1);
        apb(1'b1, stwd_pkg::OFS_CTRL, 32'h0);
        apb(1'b0, stwd_pkg::OFS_IRQ_STATUS, 32'h0);
        watch(1, 100, 1'b0);
        // Freeze is ignored until enabled, then stops the timer.
        debug_freeze <= 1'b1;
        rise(200, 1'b1, per);
        rise(200, 1'b1, per);
        chk(32'(per), 32'd12, "period while freeze ignored");
        apb(1'b1, stwd_pkg::OFS_CTRL, 32'h10);
        rise(20, 1'b0, per);
        rise(200, 1'b0, per);
        chk(32'(per), 32'd201, "frozen timer still ticking");
        debug_freeze <= 1'b0;
        rise(200, 1'b1, per);
        // Unserviced watchdog on the tick input clock.
        do_reset();
        apb(1'b1, stwd_pkg::OFS_CONFIG, 32'h10);
        apb(1'b1, stwd_pkg::OFS_RELOAD, 32'h3);
        watch(2, 8, 1'b0);
        watch(2, 40, 1'b1);
        // Unserviced watchdog on the tick pulse, period 12 cycles.
        do_reset();
        apb(1'b1, stwd_pkg::OFS_PRESET, 32'h2);
        apb(1'b1, stwd_pkg::OFS_CTRL, 32'h1);
        apb(1'b1, stwd_pkg::OFS_RELOAD, 32'h2);
        watch(2, 20, 1'b0);
        watch(2, 40, 1'b1);
        // Reload writes keep the watchdog alive well past one count period.
        do_reset();
        apb(1'b1, stwd_pkg::OFS_CONFIG, 32'h10);
        apb(1'b1, stwd_pkg::OFS_PRESCALE, 32'h2);
        for (int i = 0; i < 6; i++) begin
            apb(1'b1, stwd_pkg::OFS_RELOAD, 32'h4);
            watch(2, 26, 1'b0);
        end
        // Key servicing, then a wrong key.
        do_reset();
        apb(1'b1, stwd_pkg::OFS_CONFIG, 32'h30);
        apb(1'b1, stwd_pkg::OFS_PRESCALE, 32'h3);
        apb(1'b1, stwd_pkg::OFS_RELOAD, 32'h4);
        watch(2, 40, 1'b0);
        for (int i = 0; i < 5; i++) begin
            apb(1'b1, stwd_pkg::OFS_KEY, 32'h5C);
            watch(2, 40, 1'b0);
        end
        apb(1'b1, stwd_pkg::OFS_KEY, 32'hA3);
        watch(2, 10, 1'b1);
        // Key writes are ignored while key servicing is off.
        do_reset();
        apb(1'b1, stwd_pkg::OFS_CONFIG, 32'h10);
        apb(1'b1, stwd_pkg::OFS_KEY, 32'h33);
        watch(2, 100, 1'b0);
        // Full setup order, then two keys just after one tick pulse.
        // The watchdog clock is the tick pulse here, so the keys land at a known place in its 132-cycle period.
        do_reset();
        apb(1'b1, stwd_pkg::OFS_PRESET, 32'h20);
        apb(1'b1, stwd_pkg::OFS_RELOAD, 32'hFF);
        apb(1'b1, stwd_pkg::OFS_CTRL, 32'h1);
        apb(1'b1, stwd_pkg::OFS_CONFIG, 32'h2F);
        watch(2, 40, 1'b0);
        rise(300, 1'b1, per);
        apb(1'b1, stwd_pkg::OFS_KEY, 32'h5C);
        rd(stwd_pkg::OFS_CTRL, 32'h8, 32'h8);
        apb(1'b1, stwd_pkg::OFS_KEY, 32'h5C);
        watch(2, 10, 1'b1);
        print_verdict();
    end
endmodule
`default_nettype wire
